// ===== fst_monitor.sv
/* Concurrent checks on the full-scan test control top ports.
   Assumes one clock, a synchronous active-high reset, and a bind from the bench. */
`timescale 1ns/1ps
module fst_monitor
   import fst_pkg::*;
#(
   parameter int C0_LEN = CH0_LEN,
   parameter int NP     = N_PADS
) (
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  ce,
   input wire logic                  scan_shift_select,
   input wire logic                  test_fix_enable,
   input wire logic                  scan_in0,
   input wire logic                  scan_out0,
   input wire logic                  func_clear,
   input wire logic [C0_LEN-1:0]     func_din,
   input wire logic [C0_LEN-1:0]     func_dout,
   input wire logic [MEM_DATA_W-1:0] mem_q,
   input wire logic [NP-1:0]         pad_out,
   input wire logic [NP-1:0]         pad_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Chain movement in shift mode
   shift_adv_a: assert property (ce && scan_shift_select |=>
      func_dout == {$past(func_dout[C0_LEN-2:0]), $past(scan_in0)})
      else $error("chain 0 shift wrong");
   tail_out_a: assert property ((ce && scan_shift_select) [*2] |=>
      scan_out0 == $past(func_dout[C0_LEN-3], 2)) else $error("scan out tail wrong");
   mem_chain_a: assert property (ce && scan_shift_select |=>
      mem_q[MEM_DATA_W-1:1] == $past(mem_q[MEM_DATA_W-2:0])) else $error("chain 1 shift wrong");
   // Capture, freeze and reset
   capture_a: assert property (ce && test_fix_enable && !scan_shift_select && !func_clear
      |=> func_dout[C0_LEN-1:4] == ($past(func_din[C0_LEN-1:4]) ^ $past(func_dout[C0_LEN-2:3])))
      else $error("capture upper bits wrong");
   freeze_a: assert property (!ce |=> $stable(func_dout) && $stable(mem_q))
      else $error("state moved with clock enable low");
   reset_a: assert property (disable iff (1'b0) rst && ce |=>
      func_dout == '0 && mem_q == '0 && !scan_out0) else $error("reset did not clear");
   // Pad directions
   shift_pads_a: assert property (scan_shift_select && !test_fix_enable |->
      pad_oe_n == {NP{OE_RELEASE}}) else $error("pad driven in shift");
   si_pad_a: assert property (test_fix_enable |-> pad_oe_n[PAD_SI] == OE_RELEASE)
      else $error("scan in pad not input");
   so_pad_a: assert property (test_fix_enable |-> pad_oe_n[PAD_SO] == OE_DRIVE &&
      pad_out[PAD_SO] == mem_q[MEM_DATA_W-1]) else $error("scan out pad wrong");
   // Main scenarios
   cover property ((ce && scan_shift_select) [*8]);
   cover property (ce && !scan_shift_select && test_fix_enable);
   cover property (scan_shift_select && !test_fix_enable);
endmodule // fst_monitor

// ===== fst_pad_ctrl.sv
/*
 Direction control of the bidirectional pads, two of which double as
 scan data input and scan data output. Assumes the pad cell outside
 resolves the wire from out and the active-low enable.
*/
`timescale 1ns/1ps
module fst_pad_ctrl
   import fst_pkg::*;
#(
   parameter int NP = N_PADS
) (
   fst_scan_if.pad            sif,
   input  wire logic [NP-1:0] func_oe_n,
   input  wire logic [NP-1:0] func_out,
   input  wire logic          so_bit,
   input  wire logic [NP-1:0] pad_in,
   output logic      [NP-1:0] pad_out,
   output logic      [NP-1:0] pad_oe_n,
   output logic               si_bit
);
   // Per-pad direction: scan pins fixed by test-fix, rest input in shift
   generate
      for (genvar i = 0; i < NP; i++) begin : g_pad
         if (i == PAD_SI) begin : g_si
            assign pad_oe_n[i] = sif.test_fix ? OE_RELEASE :
                                 (sif.shift ? OE_RELEASE : func_oe_n[i]);
            assign pad_out[i]  = func_out[i];
         end else if (i == PAD_SO) begin : g_so
            assign pad_oe_n[i] = sif.test_fix ? OE_DRIVE :
                                 (sif.shift ? OE_RELEASE : func_oe_n[i]);
            assign pad_out[i]  = sif.test_fix ? so_bit : func_out[i];
         end else begin : g_fn
            assign pad_oe_n[i] = sif.shift ? OE_RELEASE : func_oe_n[i];
            assign pad_out[i]  = func_out[i];
         end
      end
   endgenerate

   // Scan input shares a pad; nothing else reads it as clock or reset
   assign si_bit = pad_in[PAD_SI];
endmodule // fst_pad_ctrl

// ===== fst_pkg.sv
/*
 Shared constants for the full-scan test control block: chain layouts,
 field positions, pad roles and fixed test values.
 Assumes every module of the block imports it whole.
*/
package fst_pkg;
   // Chain 0: functional accumulator flops
   localparam int CH0_LEN       = 8;
   // Chain 1: flops around the embedded memory
   localparam int MEM_ADDR_W    = 2;
   localparam int MEM_DATA_W    = 4;
   localparam int MEM_DEPTH     = 4;
   localparam int CH1_ADDR_LSB  = 0;
   localparam int CH1_WDATA_LSB = CH1_ADDR_LSB + MEM_ADDR_W;
   localparam int CH1_WE_BIT    = CH1_WDATA_LSB + MEM_DATA_W;
   localparam int CH1_RDATA_LSB = CH1_WE_BIT + 1;
   localparam int CH1_LEN       = CH1_RDATA_LSB + MEM_DATA_W;
   // Bidirectional pads and the two that double as scan pins
   localparam int N_PADS        = 4;
   localparam int PAD_SI        = 0;
   localparam int PAD_SO        = 1;
   // Fixed values forced while the test-fix enable is high
   localparam logic SR_FIX_VAL  = 1'h0;
   localparam logic DIV_FIX_VAL = 1'h0;
   localparam logic PULSE_FIX   = 1'h0;
   // Non-scanned divider inside the fixed-function macro
   localparam int DIV_W         = 4;
   // Output enables, active low
   localparam logic OE_DRIVE    = 1'h0;
   localparam logic OE_RELEASE  = 1'h1;
endpackage

// ===== fst_scan_chain.sv
/*
 One chain of mux-input scan flops, parameterised in length.
 Assumes a single clock and that the caller supplies functional data,
 the functional load enable and the functional clear.
*/
`timescale 1ns/1ps
module fst_scan_chain
   import fst_pkg::*;
#(
   parameter int LEN = CH0_LEN
) (
   input  wire logic           clk,
   input  wire logic           rst,
   fst_scan_if.chain           sif,
   input  wire logic [LEN-1:0] func_d,
   input  wire logic           load_en,
   input  wire logic           clear,
   input  wire logic           si,
   output logic      [LEN-1:0] q,
   output logic                so
);
   logic [LEN-1:0] q_r;
   logic [LEN-1:0] q_nxt;
   logic [LEN-1:0] chain_d;

   // Serial path: head takes scan input, each bit takes its neighbour
   assign chain_d[0] = si;
   generate
      for (genvar i = 1; i < LEN; i++) begin : g_link
         assign chain_d[i] = q_r[i-1];
      end
   endgenerate

   // Per-flop mux; shift wins, so clear stays inactive while shifting
   always_comb begin
      if (sif.shift) begin
         q_nxt = chain_d;
      end else if (clear) begin
         q_nxt = '0;
      end else if (load_en) begin
         q_nxt = func_d;
      end else begin
         q_nxt = q_r;
      end
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (rst) begin
         q_r <= '0;
      end else if (sif.run) begin
         q_r <= q_nxt;
      end
   end

   assign q  = q_r;
   assign so = q_r[LEN-1];
endmodule // fst_scan_chain

// ===== fst_scan_if.sv
/*
 Test-mode controls carried from the top to the scan chains and pads.
 Assumes the top alone drives it, from its dedicated test pins.
*/
`timescale 1ns/1ps
interface fst_scan_if;
   logic shift;    // Chains form shift registers
   logic test_fix; // Test-fix forcing active
   logic run;      // Clock enable, freezes all state when low

   modport ctrl  (output shift, output test_fix, output run);
   modport chain (input shift, input test_fix, input run);
   modport pad   (input shift, input test_fix, input run);
endinterface

// ===== fst_tester.sv
/* Scan tester model: loads both chains serially and unloads them.
   Assumes the bench raises go at a falling edge and holds the pattern. */
`timescale 1ns/1ps
module fst_tester
   import fst_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic [3:0]  n_sh,
   input  wire logic [10:0] pat0,
   input  wire logic [10:0] pat1,
   input  wire logic        so0,
   input  wire logic        so1,
   output logic             shift,
   output logic             si0,
   output logic             si1,
   output logic             busy,
   output logic [10:0]      got0,
   output logic [10:0]      got1
);
   int k = 0;

   initial {shift, si0, si1, busy, got0, got1} = '0;

   // One bit per edge, most significant first, unload sampled before the edge
   always begin
      @(negedge clk);
      if (go && !busy) begin
         busy = 1'h1;
         k = n_sh;
      end
      if (busy && k > 0) begin
         // Tail settled since the last edge; take it before this edge moves it
         got0 = {got0[9:0], so0};
         got1 = {got1[9:0], so1};
         shift = 1'h1;
         si0 = pat0[k-1];
         si1 = pat1[k-1];
         @(posedge clk);
         k--;
      end else begin
         // Idle: select low, released data lines toggle every cycle
         shift = 1'h0;
         busy = 1'h0;
         si0 = ~si0;
         si1 = ~si1;
      end
   end
endmodule // fst_tester

// ===== fst_top.sv
/*
 Full mux-scan test control around a small functional core: two scan
 chains, an embedded memory wrapped in scan flops, a former internal
 bus, a latch, asynchronous helpers and a non-scanned divider.
 Assumes one system clock that also serves as scan clock, synchronous
 inputs, and an outside tester driving the dedicated test pins. The
 pad cells sit outside and resolve each pad from its value and its
 active-low enable. Memory words start at zero after reset so that a
 capture never loads an unknown value into the wrapper flops.
*/
// Functional notes
// - One dedicated pin selects shift or capture
// - Shift mode links flops into shift registers
// - Capture mode: logic response loaded next edge
// - Shift holds set/reset inactive, fixes directions
// - Shift select pin shared with nothing
// - Test-fix pin fixes asynchronous parts, clocks
// - Each chain has own scan in/out
// - Shared scan pads forced to fixed direction
// - Scan inputs never drive clocks or resets
// - Scan clock is the system clock
// - Flop clock/set/reset controllable from pins
// - Test-fix routes one clock to all flops
// - Internal bus is a contention-free mux
// - Scan flops around embedded memory ports
// - Latches transparent under test-fix
// - Bidirectional pads input during shift; the scan out pad is driven when test-fix is high
// - Asynchronous structure outputs forced constant
// - Non-scanned flop outputs held constant
// - Full scan with mux-input flops
`timescale 1ns/1ps
module fst_top
   import fst_pkg::*;
#(
   parameter int C0_LEN = CH0_LEN,
   parameter int NP     = N_PADS
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire logic              scan_shift_select,
   input  wire logic              test_fix_enable,
   input  wire logic              scan_in0,
   output logic                   scan_out0,
   input  wire logic              func_tick_a,
   input  wire logic              func_tick_b,
   input  wire logic              func_clear,
   input  wire logic [C0_LEN-1:0] func_din,
   output logic      [C0_LEN-1:0] func_dout,
   output logic [MEM_DATA_W-1:0]  mem_q,
   input  wire logic              bus_req_a,
   input  wire logic              bus_req_b,
   input  wire logic              latch_en,
   input  wire logic              latch_d,
   input  wire logic              sr_set,
   input  wire logic              sr_clr,
   input  wire logic              edge_in,
   input  wire logic [NP-1:0]     pad_in,
   output logic      [NP-1:0]     pad_out,
   output logic      [NP-1:0]     pad_oe_n,
   input  wire logic [NP-1:0]     func_pad_out,
   input  wire logic [NP-1:0]     func_pad_oe_n
);
   // Mode controls shared by both chains and the pad logic
   fst_scan_if sif ();

   // Chain state and serial ends
   logic [C0_LEN-1:0]     c0_q;
   logic [C0_LEN-1:0]     c0_d;
   logic                  c0_so;
   logic [CH1_LEN-1:0]    c1_q;
   logic [CH1_LEN-1:0]    c1_d;
   logic                  c1_so;
   logic                  c1_si;

   // Effective clock roots and clear
   logic                  tick_a_eff;
   logic                  tick_b_eff;
   logic                  clear_eff;

   // Former internal bus
   logic                  bus_en_a;
   logic                  bus_en_b;
   logic [MEM_DATA_W-1:0] bus_val;

   // Non-scanned helpers and their forced outputs
   logic                  latch_q_r;
   logic                  latch_q_nxt;
   logic                  latch_eff;
   logic                  sr_q_r;
   logic                  sr_q_nxt;
   logic                  sr_eff;
   logic                  edge_d_r;
   logic                  edge_d_nxt;
   logic                  pulse_eff;
   logic [DIV_W-1:0]      div_r;
   logic [DIV_W-1:0]      div_nxt;
   logic                  div_eff;

   // Embedded memory and its wrapper ports
   logic [MEM_DATA_W-1:0] mem_r [MEM_DEPTH];
   logic [MEM_ADDR_W-1:0] mem_addr;
   logic [MEM_DATA_W-1:0] mem_wdata;
   logic                  mem_we;
   logic                  mem_wr_en;
   logic [MEM_DATA_W-1:0] mem_rdata;

   // Chain 0 feedback mix
   logic [MEM_DATA_W-1:0] acc_mix;

   // Dedicated test pins drive the mode controls, nothing functional.
   // Sharing the shift select with a data pin would let the tester's
   // mode changes leak into the function, so it has a pin of its own.
   assign sif.shift    = scan_shift_select;
   assign sif.test_fix = test_fix_enable;
   assign sif.run      = ce;

   // Clock roots: under test-fix every scanned flop sees the one clock
   // edge, the functional per-root enables being bypassed. Functionally
   // each root gates its own chain; a tester cannot reproduce that
   // gating, so test-fix ties both roots to the system clock pin and
   // one edge moves every scanned flop at once
   always_comb begin
      if (test_fix_enable) begin
         tick_a_eff = 1'h1;
         tick_b_eff = 1'h1;
      end else begin
         tick_a_eff = func_tick_a;
         tick_b_eff = func_tick_b;
      end
   end

   // Functional clear comes straight from its pin, idle in shift.
   // A clear while shifting would wipe a half-loaded pattern, so the
   // select pin masks it here as well as inside each chain.
   assign clear_eff = func_clear & ~scan_shift_select;

   // Former internal 3-state bus as a mux with one-hot enables. A
   // real 3-state net would float or fight under test patterns; here
   // source A always wins and test-fix leaves A as the only source.
   always_comb begin
      if (test_fix_enable) begin
         bus_en_a = 1'h1;
         bus_en_b = 1'h0;
      end else begin
         bus_en_a = bus_req_a;
         bus_en_b = bus_req_b & ~bus_req_a;
      end
   end

   // Bus value; idle bus reads as zero instead of floating,
   // so no pattern ever observes an unknown level
   always_comb begin
      if (bus_en_a) begin
         bus_val = c0_q[MEM_DATA_W-1:0];
      end else if (bus_en_b) begin
         bus_val = {MEM_DATA_W{latch_eff}};
      end else begin
         bus_val = '0;
      end
   end

   // Level latch modelled as held bit; its gate is an ordinary pin,
   // so away from test-fix it follows the function alone
   always_comb begin
      latch_q_nxt = latch_en ? latch_d : latch_q_r;
   end

   // Latch register
   always_ff @(posedge clk) begin
      if (rst) begin
         latch_q_r <= 1'h0;
      end else if (ce) begin
         latch_q_r <= latch_q_nxt;
      end
   end

   // Set-reset latch; set wins when both inputs are high, a race
   // that test-fix hides by pinning the output
   always_comb begin
      if (sr_set) begin
         sr_q_nxt = 1'h1;
      end else if (sr_clr) begin
         sr_q_nxt = 1'h0;
      end else begin
         sr_q_nxt = sr_q_r;
      end
   end

   // Set-reset register
   always_ff @(posedge clk) begin
      if (rst) begin
         sr_q_r <= 1'h0;
      end else if (ce) begin
         sr_q_r <= sr_q_nxt;
      end
   end

   // Edge differentiator: last input level, its one-cycle pulse
   // being pinned under test-fix
   always_comb begin
      edge_d_nxt = edge_in;
   end

   // Edge history register
   always_ff @(posedge clk) begin
      if (rst) begin
         edge_d_r <= 1'h0;
      end else if (ce) begin
         edge_d_r <= edge_d_nxt;
      end
   end

   // Divider of the fixed macro: not on a chain, so its count cannot
   // be set by a pattern and its output is pinned under test-fix
   always_comb begin
      div_nxt = div_r + {{(DIV_W-1){1'h0}}, 1'h1};
   end

   // Divider register
   always_ff @(posedge clk) begin
      if (rst) begin
         div_r <= '0;
      end else if (ce) begin
         div_r <= div_nxt;
      end
   end

   // Test-fix forcing: the latch opens, racing and unscanned outputs
   // are pinned. Each would otherwise carry state that the chains
   // cannot set, and one unknown spoils every later pattern.
   always_comb begin
      if (test_fix_enable) begin
         latch_eff = latch_d;
         sr_eff    = SR_FIX_VAL;
         pulse_eff = PULSE_FIX;
         div_eff   = DIV_FIX_VAL;
      end else begin
         latch_eff = latch_q_r;
         sr_eff    = sr_q_r;
         pulse_eff = edge_in & ~edge_d_r;
         div_eff   = div_r[DIV_W-1];
      end
   end

   // Chain 0 functional input: data pins mixed with core state.
   // The low nibble also sees the bus and every forced helper, so a
   // capture makes the forcing visible at the chain outputs.
   always_comb begin
      acc_mix = bus_val ^ {sr_eff, pulse_eff, div_eff, latch_eff};
      c0_d    = func_din ^ {c0_q[C0_LEN-2:0], c0_q[C0_LEN-1]};
      c0_d[MEM_DATA_W-1:0] = c0_d[MEM_DATA_W-1:0] ^ acc_mix;
   end

   // Chain 0: accumulator flops, own dedicated scan pins
   fst_scan_chain #(
      .LEN (C0_LEN)
   ) u_chain0 (
      .clk     (clk),
      .rst     (rst),
      .sif     (sif),
      .func_d  (c0_d),
      .load_en (tick_a_eff),
      .clear   (clear_eff),
      .si      (scan_in0),
      .q       (c0_q),
      .so      (c0_so)
   );
   // Chain 0 ends go straight to pins
   assign scan_out0 = c0_so;
   assign func_dout = c0_q;

   // Memory ports come from chain 1 flops so they are controllable,
   // and the read data lands in flops that the chain can observe
   assign mem_addr  = c1_q[CH1_ADDR_LSB +: MEM_ADDR_W];
   assign mem_wdata = c1_q[CH1_WDATA_LSB +: MEM_DATA_W];
   assign mem_we    = c1_q[CH1_WE_BIT];
   assign mem_rdata = mem_r[mem_addr];

   // Write strobe; blocked while shifting so scan data never lands in
   // the array, and frozen with the clock enable like every flop
   always_comb begin
      mem_wr_en = ce & mem_we & ~scan_shift_select;
   end

   // Memory entries, cleared by reset so that a capture reading a word
   // never written loads a known value; one register set per entry
   // keeps each word's write decode next to its storage
   generate
      for (genvar e = 0; e < MEM_DEPTH; e++) begin : g_mem
         always_ff @(posedge clk) begin
            if (rst) begin
               mem_r[e] <= '0;
            end else if (mem_wr_en && (mem_addr == MEM_ADDR_W'(e))) begin
               mem_r[e] <= mem_wdata;
            end
         end
      end
   endgenerate

   // Chain 1 functional input: memory request and observed read data;
   // read data comes from the address that the chain holds now
   always_comb begin
      c1_d = c1_q;
      c1_d[CH1_ADDR_LSB +: MEM_ADDR_W]  = func_din[MEM_ADDR_W-1:0];
      c1_d[CH1_WDATA_LSB +: MEM_DATA_W] = c0_q[MEM_DATA_W-1:0];
      c1_d[CH1_WE_BIT]                  = func_din[C0_LEN-1];
      c1_d[CH1_RDATA_LSB +: MEM_DATA_W] = mem_rdata;
   end

   // Chain 1: memory wrapper flops, scan pins shared with pads
   fst_scan_chain #(
      .LEN (CH1_LEN)
   ) u_chain1 (
      .clk     (clk),
      .rst     (rst),
      .sif     (sif),
      .func_d  (c1_d),
      .load_en (tick_b_eff),
      .clear   (clear_eff),
      .si      (c1_si),
      .q       (c1_q),
      .so      (c1_so)
   );
   // Captured read data stands on its own port for observation
   assign mem_q = c1_q[CH1_RDATA_LSB +: MEM_DATA_W];

   // Pad directions and the shared scan pins of chain 1.
   // Chain 1 reaches the tester through two shared pads, chain 0
   // through pins of its own.
   fst_pad_ctrl #(
      .NP (NP)
   ) u_pads (
      .sif       (sif),
      .func_oe_n (func_pad_oe_n),
      .func_out  (func_pad_out),
      .so_bit    (c1_so),
      .pad_in    (pad_in),
      .pad_out   (pad_out),
      .pad_oe_n  (pad_oe_n),
      .si_bit    (c1_si)
   );
endmodule // fst_top

// ===== fst_top_tb_top.sv
/* Self-checking bench for the full-scan test control top with a tester model.
   Assumes a 200 MHz clock and all inputs driven at the falling edge. */
`timescale 1ns/1ps
module fst_top_tb_top;
   import fst_pkg::*;
   localparam logic [7:0] DIN = 8'h5a;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   logic        ce_tb = 1'h1;
   logic        tfe = 1'h0;
   logic        fclr = 1'h0;
   logic        go = 1'h0;
   logic [3:0]  n_sh = 4'h0;
   logic [10:0] pat0 = 11'h0, pat1 = 11'h0, ctl = 11'h0;
   logic [3:0]  fpo = 4'h0, foe = 4'hf;
   logic        shift, si0, si1, busy, scan_out0;
   logic [10:0] got0, got1;
   logic [7:0]  func_dout;
   logic [3:0]  mem_q, pad_out, pad_oe_n;
   int          mismatches = 0;
   int          n_checks = 0;
   wire logic   ce = ce_tb | shift;
   // Pad 1 has a pull-up when released; pad 0 carries the tester's chain 1 input
   wire logic [3:0] pad_in = {ctl[10:9], pad_oe_n[PAD_SO] == OE_DRIVE ? pad_out[PAD_SO] : 1'h1, si1};

   fst_top fst_top_i (
      .clk(clk), .rst(rst), .ce(ce), .scan_shift_select(shift), .test_fix_enable(tfe),
      .scan_in0(si0), .scan_out0(scan_out0), .func_tick_a(ctl[0]), .func_tick_b(ctl[1]),
      .func_clear(fclr), .func_din(DIN), .func_dout(func_dout), .mem_q(mem_q),
      .bus_req_a(ctl[2]), .bus_req_b(ctl[3]), .latch_en(ctl[4]), .latch_d(ctl[5]),
      .sr_set(ctl[6]), .sr_clr(ctl[7]), .edge_in(ctl[8]), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe_n(pad_oe_n), .func_pad_out(fpo), .func_pad_oe_n(foe));
   fst_tester fst_tester_i (
      .clk(clk), .go(go), .n_sh(n_sh), .pat0(pat0), .pat1(pat1), .so0(scan_out0),
      .so1(pad_in[PAD_SO]), .shift(shift), .si0(si0), .si1(si1), .busy(busy),
      .got0(got0), .got1(got1));

   // Clock
   always #2.5 clk = ~clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Serial load and unload through the tester, ends once it goes idle
   task automatic run(input logic [3:0] n, input logic [10:0] p0, input logic [10:0] p1);
      @(negedge clk);
      n_sh <= n;
      pat0 <= p0;
      pat1 <= p1;
      go <= 1'h1;
      @(negedge clk);
      go <= 1'h0;
      for (int w = 0; w < 20 && (busy || w == 0); w++)
         @(posedge clk);
      #1;
   endtask

   // One enabled capture edge
   task automatic capture;
      @(negedge clk);
      ce_tb <= 1'h1;
      @(negedge clk);
      ce_tb <= 1'h0;
      #1;
   endtask

   task automatic t_reset;
      chk(16'({scan_out0, mem_q, func_dout}), 16'h0000);
   endtask

   task automatic t_pads;
      @(negedge clk);
      fpo <= 4'h9;
      foe <= 4'h6;
      #1;
      chk(16'({pad_out, pad_oe_n}), 16'h0096);
      fork
         run(4'h4, 11'h000, 11'h000);
         begin
            repeat (3) @(negedge clk);
            #1;
            chk(16'(pad_oe_n), 16'h000f);
         end
      join
      @(negedge clk);
      tfe <= 1'h1;
      #1;
      chk(16'(pad_oe_n[1:0]), 16'h0001);
   endtask

   task automatic t_shift;
      @(negedge clk);
      fclr <= 1'h1;
      run(4'hb, 11'h03c, 11'h5a3);
      run(4'hb, 11'h0c3, 11'h2a6);
      chk(16'(got0[10:3]), 16'h003c);
      chk(16'(got1), 16'h05a3);
      chk(16'(func_dout), 16'h00c3);
      @(negedge clk);
      fclr <= 1'h0;
   endtask

   // Same loaded state captured twice, every control pin flipped; only the latch data shows
   task automatic t_capture;
      logic [7:0] r0;
      run(4'hb, 11'h096, 11'h000);
      capture();
      r0 = func_dout;
      chk(16'(r0[7:4]), 16'(DIN[7:4] ^ 4'h2));
      run(4'hb, 11'h096, 11'h000);
      @(negedge clk);
      ctl <= 11'h7ff;
      capture();
      chk(16'(func_dout ^ r0), 16'h0001);
   endtask

   // Write through the wrapped memory, then read back the same address
   task automatic t_mem;
      run(4'hb, 11'h009, 11'h066);
      capture();
      run(4'hb, 11'h000, 11'h002);
      capture();
      chk(16'(mem_q), 16'h0009);
   endtask

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst <= 1'h0;
      ce_tb <= 1'h0;
      @(negedge clk);
      t_reset();
      t_pads();
      t_shift();
      t_capture();
      t_mem();
      test_done();
   end

   // Watchdog
   initial begin
      #5000;
      mismatches++;
      test_done();
   end
endmodule // fst_top_tb_top

bind fst_top fst_monitor #(.C0_LEN(C0_LEN), .NP(NP)) fst_monitor_i (
   .clk(clk), .rst(rst), .ce(ce), .scan_shift_select(scan_shift_select),
   .test_fix_enable(test_fix_enable), .scan_in0(scan_in0), .scan_out0(scan_out0),
   .func_clear(func_clear), .func_din(func_din), .func_dout(func_dout), .mem_q(mem_q),
   .pad_out(pad_out), .pad_oe_n(pad_oe_n));
